/* File: rtl/pxs_pkg.sv */
// Package of constants and types for the seven-to-one pixel serializer.
package pxs_pkg;
    localparam int PXS_BITS = 28;
    localparam int PXS_LANES = 4;
    localparam int PXS_SLOTS = 7;
    // Slots for which the forwarded clock stays high.
    localparam int PXS_CLK_HIGH_SLOTS = 4;
    // Capture edges of the pixel clock, counted whatever their spacing, before lanes are declared valid.
    localparam int PXS_LOCK_PERIODS = 8;
    localparam logic [2:0] PXS_SLOT_RESET = 3'h0;

    typedef enum logic [1:0] {
        PXS_OFF,
        PXS_LOCKING,
        PXS_RUN
    } pxs_mode_e;

    // Bit index of parallel input for a slot and lane.
    function automatic int pxs_bit_index(input int slot, input int lane);
        int t [0:27];
        t = '{1, 9, 20, 5, 0, 8, 19, 27, 7, 18, 26, 23, 6, 15, 25, 17,
              4, 14, 24, 16, 3, 13, 22, 11, 2, 12, 21, 10};
        return t[slot * 4 + lane];
    endfunction : pxs_bit_index
endpackage : pxs_pkg

/* File: rtl/pxs_fifo.sv */
// Small flip-flop FIFO carrying captured pixel words into the slot sequencer.
`timescale 1ns/1ps
module pxs_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 8
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic clear_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    // Flags come straight from the occupancy count.
    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign do_wr = in_valid_in && in_ready_out;
    assign do_rd = out_valid_out && out_ready_in;

    // Storage and pointers; a clear empties the FIFO without touching data words.
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (ce_in) begin
            if (clear_in) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count <= '0;
            end else begin
                if (do_wr) begin
                    mem[wr_ptr] <= in_data_in;
                    wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
                end
                if (do_rd) begin
                    rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
                end
                count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
            end
        end
    end
endmodule : pxs_fifo

/* File: rtl/pxs_serializer.sv */
// Seven-to-one pixel serializer: capture, buffering, slot sequencing and clock forwarding.
`timescale 1ns/1ps
module pxs_serializer
    import pxs_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int LOCK_PERIODS = PXS_LOCK_PERIODS
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic pixel_input_clock_in,
    input wire logic capture_edge_select_in,
    input wire logic power_down_n_in,
    input wire logic [PXS_BITS-1:0] parallel_pixel_bits_in,
    output logic [PXS_LANES-1:0] serial_lane_out,
    output logic [PXS_LANES-1:0] serial_lane_oe_out,
    output logic forwarded_link_clock_out,
    output logic forwarded_link_clock_oe_out,
    output logic lane_valid_out,
    output logic overflow_out
);
    // Whole state of the block, apart from the FIFO, in one record.
    typedef struct packed {
        logic [1:0] clk_sync;
        logic [1:0] sel_sync;
        logic [1:0] pd_sync;
        logic clk_prev;
        logic [PXS_BITS-1:0] data_s1;
        logic [PXS_BITS-1:0] data_s2;
        pxs_mode_e mode;
        logic [15:0] lock_cnt;
        logic [15:0] period_cnt;
        logic [15:0] period_len;
        logic [15:0] slot_cnt;
        logic [2:0] slot;
        logic [PXS_BITS-1:0] word;
        logic word_ok;
        logic [PXS_LANES-1:0] lane;
        logic lane_oe;
        logic fclk;
        logic fclk_oe;
        logic valid;
        logic ovf;
    } pxs_state_s;

    pxs_state_s st;
    pxs_state_s next_st;

    logic cap_edge;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [PXS_BITS-1:0] fifo_data;
    logic fifo_clear;

    // Length of one slot in system clocks, from the measured pixel period.
    function automatic logic [15:0] slot_len(input logic [15:0] period);
        return (period / 16'h7 == 16'h0) ? 16'h1 : period / 16'h7;
    endfunction : slot_len

    // Lane bits for one slot, picked from a captured word.
    function automatic logic [PXS_LANES-1:0] slot_bits(input logic [PXS_BITS-1:0] w, input logic [2:0] s);
        logic [PXS_LANES-1:0] r;
        r = '0;
        for (int l = 0; l < PXS_LANES; l++) begin
            r[l] = w[pxs_bit_index(int'(s), l)];
        end
        return r;
    endfunction : slot_bits

    // Edge finding uses the second synchroniser stage against a delayed copy only.
    always_comb begin
        if (st.sel_sync[1]) begin
            cap_edge = st.clk_sync[1] && !st.clk_prev;
        end else begin
            cap_edge = !st.clk_sync[1] && st.clk_prev;
        end
    end

    // Data pins are sampled twice; the pixel clock is slow next to mclk, so the word is settled at the edge.
    assign fifo_clear = (st.mode == PXS_OFF);

    pxs_fifo #(
        .WIDTH(PXS_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .clear_in(fifo_clear),
        .in_valid_in(cap_edge && st.mode != PXS_OFF),
        .in_ready_out(fifo_in_ready),
        .in_data_in(st.data_s2),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_data)
    );

    // A word is loaded at each slot-0 boundary when one is waiting.
    assign fifo_pop = (st.mode == PXS_RUN) && (st.slot == 3'h6) &&
                      (st.slot_cnt + 16'h1 >= slot_len(st.period_len));

    // Next-state logic for the whole block.
    always_comb begin
        next_st = st;
        next_st.clk_sync = {st.clk_sync[0], pixel_input_clock_in};
        next_st.sel_sync = {st.sel_sync[0], capture_edge_select_in};
        next_st.pd_sync = {st.pd_sync[0], power_down_n_in};
        next_st.clk_prev = st.clk_sync[1];
        next_st.data_s1 = parallel_pixel_bits_in;
        next_st.data_s2 = st.data_s1;

        // Pixel period is measured between capture edges so the output period follows it.
        if (cap_edge) begin
            next_st.period_len = st.period_cnt + 16'h1;
            next_st.period_cnt = 16'h0;
        end else if (st.period_cnt != 16'hffff) begin
            next_st.period_cnt = st.period_cnt + 16'h1;
        end

        // A word lost because the FIFO was full is reported, sticky until power-down.
        if (cap_edge && st.mode != PXS_OFF && !fifo_in_ready) begin
            next_st.ovf = 1'b1;
        end

        case (st.mode)
            PXS_OFF: begin
                next_st.lane_oe = 1'b0;
                next_st.fclk_oe = 1'b0;
                next_st.valid = 1'b0;
                next_st.lane = '0;
                next_st.fclk = 1'b0;
                next_st.ovf = 1'b0;
                next_st.lock_cnt = 16'h0;
                next_st.slot = PXS_SLOT_RESET;
                next_st.slot_cnt = 16'h0;
                next_st.word_ok = 1'b0;
                if (st.pd_sync[1]) begin
                    next_st.mode = PXS_LOCKING;
                end
            end
            PXS_LOCKING: begin
                // Lock is declared after LOCK_PERIODS capture edges, whatever their spacing; lanes stay invalid until then.
                next_st.lane_oe = 1'b1;
                next_st.fclk_oe = 1'b1;
                if (cap_edge) begin
                    if (st.lock_cnt + 16'h1 >= 16'(LOCK_PERIODS)) begin
                        next_st.mode = PXS_RUN;
                        next_st.slot = 3'h6;
                        next_st.slot_cnt = 16'h0;
                    end else begin
                        next_st.lock_cnt = st.lock_cnt + 16'h1;
                    end
                end
            end
            PXS_RUN: begin
                next_st.valid = st.word_ok;
                if (st.slot_cnt + 16'h1 >= slot_len(st.period_len)) begin
                    next_st.slot_cnt = 16'h0;
                    if (st.slot == 3'h6) begin
                        // Whole word swapped only at the slot-0 boundary, never mid-period.
                        next_st.slot = 3'h0;
                        if (fifo_out_valid) begin
                            next_st.word = fifo_data;
                            next_st.word_ok = 1'b1;
                        end else begin
                            next_st.word_ok = 1'b0;
                        end
                        next_st.lane = slot_bits(fifo_out_valid ? fifo_data : st.word, 3'h0);
                        next_st.fclk = 1'b1;
                    end else begin
                        next_st.slot = st.slot + 3'h1;
                        // Slots 1..6 follow the map for each lane.
                        next_st.lane = slot_bits(st.word, st.slot + 3'h1);
                        // High through slots 0..3, low through 4..6.
                        next_st.fclk = ((st.slot + 3'h1) < 3'(PXS_CLK_HIGH_SLOTS));
                    end
                end else begin
                    next_st.slot_cnt = st.slot_cnt + 16'h1;
                end
            end
            default: begin
                next_st.mode = PXS_OFF;
            end
        endcase

        // Power-down wins over everything and drops both drivers on the next edge.
        if (!st.pd_sync[1]) begin
            next_st.mode = PXS_OFF;
            next_st.fclk_oe = 1'b0;
            next_st.lane_oe = 1'b0;
            next_st.valid = 1'b0;
        end
    end

    // State register; clock enable freezes everything.
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            st <= '0;
            st.mode <= PXS_OFF;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    // Outputs taken straight from the state record.
    assign serial_lane_out = st.lane;
    assign serial_lane_oe_out = {PXS_LANES{st.lane_oe}};
    assign forwarded_link_clock_out = st.fclk;
    assign forwarded_link_clock_oe_out = st.fclk_oe;
    assign lane_valid_out = st.valid;
    assign overflow_out = st.ovf;
endmodule : pxs_serializer

/* File: sim/pxs_serializer_asserts.sv */
// Port-level checks for the pixel serializer.
`timescale 1ns/1ps
module pxs_serializer_asserts
    import pxs_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int LOCK_PERIODS = PXS_LOCK_PERIODS
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic pixel_input_clock_in,
    input wire logic capture_edge_select_in,
    input wire logic power_down_n_in,
    input wire logic [PXS_BITS-1:0] parallel_pixel_bits_in,
    input wire logic [PXS_LANES-1:0] serial_lane_out,
    input wire logic [PXS_LANES-1:0] serial_lane_oe_out,
    input wire logic forwarded_link_clock_out,
    input wire logic forwarded_link_clock_oe_out,
    input wire logic lane_valid_out,
    input wire logic overflow_out
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    a_clk_shape: assert property (disable iff (!rst_b_in || !power_down_n_in)
        $rose(forwarded_link_clock_out) |-> forwarded_link_clock_out [*4] ##1 !forwarded_link_clock_out [*3]
        ##1 forwarded_link_clock_out) else $error("forwarded clock shape wrong");
    a_pd_oe_off: assert property ($fell(power_down_n_in) |-> ##[1:5] !forwarded_link_clock_oe_out
        && serial_lane_oe_out == 4'h0) else $error("outputs not off after power-down");
    a_pd_oe_on: assert property ($rose(power_down_n_in) |-> ##[2:5] forwarded_link_clock_oe_out)
        else $error("outputs not enabled after power-down release");
    a_lane_oe_all: assert property (serial_lane_oe_out == 4'h0 || serial_lane_oe_out == 4'hf)
        else $error("lane enables differ");
    a_valid_driven: assert property (lane_valid_out |-> forwarded_link_clock_oe_out
        && serial_lane_oe_out == 4'hf) else $error("valid data on undriven lanes");
    a_lock_wait: assert property ($rose(forwarded_link_clock_oe_out) |-> !lane_valid_out [*8])
        else $error("lane data valid before lock");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b_in |=> !forwarded_link_clock_oe_out
        && !lane_valid_out && !overflow_out) else $error("outputs active after reset");
    a_pd_invalid: assert property (!power_down_n_in [*6] |-> !lane_valid_out)
        else $error("lane data valid in power-down");
endmodule : pxs_serializer_asserts

bind pxs_serializer pxs_serializer_asserts #(.FIFO_DEPTH(FIFO_DEPTH), .LOCK_PERIODS(LOCK_PERIODS)) u_chk (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .pixel_input_clock_in(pixel_input_clock_in),
    .capture_edge_select_in(capture_edge_select_in), .power_down_n_in(power_down_n_in),
    .parallel_pixel_bits_in(parallel_pixel_bits_in), .serial_lane_out(serial_lane_out),
    .serial_lane_oe_out(serial_lane_oe_out), .forwarded_link_clock_out(forwarded_link_clock_out),
    .forwarded_link_clock_oe_out(forwarded_link_clock_oe_out), .lane_valid_out(lane_valid_out),
    .overflow_out(overflow_out));

/* File: sim/pxs_video_src.sv */
// Video source model driving the pixel clock and parallel pixel bits.
`timescale 1ns/1ps
module pxs_video_src
    import pxs_pkg::*;
(
    input wire logic power_down_n_in,
    output logic pixel_input_clock_out,
    output logic [PXS_BITS-1:0] parallel_pixel_bits_out
);
    int black;
    // New data mid-way between edges, so a capture on the wrong edge sees a different word.
    initial begin
        pixel_input_clock_out = 1'b0;
        parallel_pixel_bits_out = '0;
        black = 0;
        forever begin
            #100;
            parallel_pixel_bits_out = black < 16 ? '0 : PXS_BITS'($urandom); // Black first.
            black = power_down_n_in ? black + 1 : 0; // Keeps sending through power-down.
            #100;
            pixel_input_clock_out = ~pixel_input_clock_out;
        end
    end
endmodule : pxs_video_src

/* File: sim/test_seven_to_one_pixel_serializer.sv */
// Self-checking bench for the pixel serializer and its FIFO.
`timescale 1ns/1ps
module test_seven_to_one_pixel_serializer
    import pxs_pkg::*;
;
    localparam int LMAP [28] = '{1, 9, 20, 5, 0, 8, 19, 27, 7, 18, 26, 23, 6, 15, 25, 17,
                                  4, 14, 24, 16, 3, 13, 22, 11, 2, 12, 21, 10};
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic pd_n = 1'b0;
    logic sel = 1'b1;
    logic pix, fclk, fclk_oe, valid, ovf, grp_valid;
    logic fclk_q = 1'b0;
    logic [PXS_BITS-1:0] bits, word;
    logic [PXS_LANES-1:0] lanes, lane_oe;
    logic [PXS_LANES-1:0] slot_lanes [0:6];
    logic [PXS_BITS-1:0] sent [$];
    int mismatches = 0;
    int n_tests = 0;
    int sc = 7;
    int seen = 0;

    pxs_video_src u_src (.power_down_n_in(pd_n), .pixel_input_clock_out(pix), .parallel_pixel_bits_out(bits));
    pxs_serializer u_dut (.mclk_in(mclk), .rst_b_in(rst_b), .ce_in(1'b1), .pixel_input_clock_in(pix),
        .capture_edge_select_in(sel), .power_down_n_in(pd_n), .parallel_pixel_bits_in(bits),
        .serial_lane_out(lanes), .serial_lane_oe_out(lane_oe), .forwarded_link_clock_out(fclk),
        .forwarded_link_clock_oe_out(fclk_oe), .lane_valid_out(valid), .overflow_out(ovf));

    // System clock, 50 ns period.
    initial begin
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [PXS_BITS-1:0] exp, input logic [PXS_BITS-1:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wrap_up;
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // Rebuild the word from seven slots; words the design dropped before leaving power-down are skipped.
    task automatic check_word;
        for (int i = 0; i < 28; i++) word[LMAP[i]] = slot_lanes[i / 4][i % 4];
        while (sent.size() > 1 && sent[0] !== word) void'(sent.pop_front());
        chk("lane_word", sent.size() > 0 ? sent[0] : 'x, word);
        if (sent.size() > 0) void'(sent.pop_front());
        seen++;
    endtask : check_word

    // Record what stands on the pins at each selected capture edge.
    always @(pix) if (pix === sel && pd_n === 1'b1) sent.push_back(bits);

    // Collect the slots of one forwarded period, starting at its rising edge.
    always @(negedge mclk) begin
        fclk_q <= fclk;
        if (fclk === 1'b1 && fclk_q === 1'b0) sc = 0;
        if (sc < 7) begin
            slot_lanes[sc] = lanes;
            if (sc == 3) grp_valid = valid;
            sc = sc + 1;
            if (sc == 7 && grp_valid === 1'b1) check_word();
        end
    end

    // With power-down still low after reset, nothing may be driven and the buffer must not report a loss.
    task automatic run_idle;
        repeat (4) @(negedge mclk);
        chk("idle_clock_oe", 28'h0, {27'h0, fclk_oe});
        chk("idle_lane_oe", 28'h0, {24'h0, lane_oe});
        chk("idle_overflow", 28'h0, {27'h0, ovf});
    endtask : run_idle

    // Main sequence: rising-edge capture first, then falling-edge capture.
    initial begin
        void'($urandom(32'hd1a817c7));
        repeat (8) @(negedge mclk);
        rst_b = 1'b1;
        run_idle();
        for (int p = 0; p < 2; p++) begin
            sel = (p == 0);
            seen = 0;
            sent.delete();
            repeat (8) @(negedge mclk);
            pd_n = 1'b1;
            repeat (600 + $urandom_range(0, 100)) @(negedge mclk);
            chk("words_seen", 28'h1, 28'(seen > 20));
            chk("overflow", 28'h0, {27'h0, ovf});
            pd_n = 1'b0;
            repeat (8) @(negedge mclk);
            chk("off_state", 28'h0, {22'h0, lane_oe, fclk_oe, valid});
        end
        wrap_up();
    end

    // Cut a hang short; the run needs under 2000 clock cycles.
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end
endmodule : test_seven_to_one_pixel_serializer
